//--- shared/dtc_cfg.svh
// Constants for the adjustment delay configuration block.
// Assumes inclusion by bare name from the package and the core module.
//
// Summary of operation
// - Local channel delay code, three bits read/write at bits 5:3.
// - Decrease wait is 8 monitoring cycles doubled per code step, up to 1024.
// - Increase wait is twice the decrease wait, 16 up to 2048 cycles.
// - Remote-2 code low bits at 7:6, top bit in neighbouring register, joined.
// - Remote-1 delay code at bits 2:0 with identical interval encoding.
// - Once the lock bit is set, writes to the delay register are ignored.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------------------
`define DTC_ADDR_DELAY      8'h37
`define DTC_ADDR_DELAY_MSB  8'h36
`define DTC_ADDR_LOCK       8'h40
`define DTC_ADDR_STATUS     8'h44

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define DTC_R1_LSB          0
`define DTC_LOC_LSB         3
`define DTC_R2LO_LSB        6
`define DTC_R2MSB_BIT       0
`define DTC_LOCK_BIT        1
`define DTC_DELAY_RST       8'h00
`define DTC_MSB_RST         8'h00

// ----------------------------------------------------------------------------
// Timing and bus response codes
// ----------------------------------------------------------------------------
`define DTC_DEC_BASE_LOG2   3
`define DTC_CNT_W           12
`define DTC_AXI_OKAY        2'b00
`define DTC_AXI_SLVERR      2'b10

`endif

//--- shared/dtc_pkg.sv
// Types for the adjustment delay configuration block.
// Assumes dtc_cfg.svh is on the include path.
`include "dtc_cfg.svh"

package dtc_pkg;

    typedef enum logic [1:0]
    {
        DTC_DIR_NONE = 2'b00,
        DTC_DIR_DEC  = 2'b01,
        DTC_DIR_INC  = 2'b11
    } dtc_dir_t;

    typedef logic [`DTC_CNT_W-1:0] dtc_cnt_t;

endpackage

//--- core/dtc_delay_cfg.sv
// Adjustment delay configuration register with per-channel interval timers.
// Assumes an AXI4-Lite master on the same clock and a monitoring tick pulse.
`timescale 1ns/1ps
`include "dtc_cfg.svh"

module dtc_delay_cfg #(
    parameter int NUM_CH = 3
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_mon_tick,
    input  wire dtc_pkg::dtc_dir_t     i_pending_dir [3],
    input  wire logic                  i_adjust_done [3],
    output logic                       o_adjust_allowed [3],
    output logic [2:0]                 o_local_delay_code,
    output logic [2:0]                 o_remote1_delay_code,
    output logic [2:0]                 o_remote2_delay_code,
    output logic                       o_locked,
    input  wire logic [9:0]            i_awaddr,
    input  wire logic                  i_awvalid,
    output logic                       o_awready,
    input  wire logic [31:0]           i_wdata,
    input  wire logic [3:0]            i_wstrb,
    input  wire logic                  i_wvalid,
    output logic                       o_wready,
    output logic [1:0]                 o_bresp,
    output logic                       o_bvalid,
    input  wire logic                  i_bready,
    input  wire logic [9:0]            i_araddr,
    input  wire logic                  i_arvalid,
    output logic                       o_arready,
    output logic [31:0]                o_rdata,
    output logic [1:0]                 o_rresp,
    output logic                       o_rvalid,
    input  wire logic                  i_rready
);
    import dtc_pkg::*;

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (NUM_CH != 3)
    begin : g_bad_num_ch
        $error("dtc_delay_cfg serves exactly three channels");
    end
    // Longest increase wait must fit the counter
    if (`DTC_CNT_W < `DTC_DEC_BASE_LOG2 + 9)
    begin : g_bad_cnt_w
        $error("dtc_delay_cfg counter too narrow for the longest wait");
    end
    if ((`DTC_LOCK_BIT > 7) || (`DTC_R2MSB_BIT > 7))
    begin : g_bad_field
        $error("dtc_delay_cfg field position outside the byte lane");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]   delay;
        logic [7:0]   delay_msb;
        logic         lock;
        logic         aw_held;
        logic [9:0]   aw_addr;
        logic         w_held;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [1:0]   rresp;
        logic [31:0]  rdata;
        dtc_cnt_t [2:0] cnt;
    } dtc_state_t;

    dtc_state_t st_q;
    dtc_state_t st_d;

    // ------------------------------------------------------------------------
    // Interval decode
    // ------------------------------------------------------------------------
    function automatic dtc_cnt_t interval(input logic [2:0] code, input dtc_dir_t dir);
        dtc_cnt_t base;
        base = dtc_cnt_t'(1) << (`DTC_DEC_BASE_LOG2 + int'(code));
        if (dir == DTC_DIR_INC)
        begin
            interval = base << 1;
        end
        else
        begin
            interval = base;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        DTC_REG_NONE   = 3'b000,
        DTC_REG_DELAY  = 3'b001,
        DTC_REG_MSB    = 3'b011,
        DTC_REG_LOCK   = 3'b010,
        DTC_REG_STATUS = 3'b110
    } dtc_reg_t;

    // Word index from byte address; unaligned addresses select nothing
    function automatic dtc_reg_t reg_sel(input logic [9:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'b00)
        begin
            reg_sel = DTC_REG_NONE;
        end
        else
        begin
            case (idx)
                `DTC_ADDR_DELAY:     reg_sel = DTC_REG_DELAY;
                `DTC_ADDR_DELAY_MSB: reg_sel = DTC_REG_MSB;
                `DTC_ADDR_LOCK:      reg_sel = DTC_REG_LOCK;
                `DTC_ADDR_STATUS:    reg_sel = DTC_REG_STATUS;
                default:             reg_sel = DTC_REG_NONE;
            endcase
        end
    endfunction

    logic [2:0] codes [3];
    logic       do_write;
    logic       do_read;

    always_comb
    begin
        codes[0] = st_q.delay[`DTC_LOC_LSB +: 3];
        codes[1] = st_q.delay[`DTC_R1_LSB +: 3];
        codes[2] = {st_q.delay_msb[`DTC_R2MSB_BIT],
                    st_q.delay[`DTC_R2LO_LSB +: 2]};
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign o_local_delay_code   = codes[0];
    assign o_remote1_delay_code = codes[1];
    assign o_remote2_delay_code = codes[2];
    assign o_locked             = st_q.lock;

    assign o_awready = !st_q.aw_held && !st_q.bvalid;
    assign o_wready  = !st_q.w_held && !st_q.bvalid;
    assign o_arready = !st_q.rvalid;
    assign o_bvalid  = st_q.bvalid;
    assign o_bresp   = st_q.bresp;
    assign o_rvalid  = st_q.rvalid;
    assign o_rresp   = st_q.rresp;
    assign o_rdata   = st_q.rdata;

    // ------------------------------------------------------------------------
    // Adjustment gating
    // ------------------------------------------------------------------------
    always_comb
    begin
        for (int c = 0; c < 3; c++)
        begin
            o_adjust_allowed[c] = (i_pending_dir[c] != DTC_DIR_NONE) &&
                (st_q.cnt[c] >= interval(codes[c], i_pending_dir[c]));
        end
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        if (o_awready && i_awvalid)
        begin
            st_d.aw_held = 1'b1;
            st_d.aw_addr = i_awaddr;
        end
        if (o_wready && i_wvalid)
        begin
            st_d.w_held = 1'b1;
            st_d.w_data = i_wdata;
            st_d.w_strb = i_wstrb;
        end
        do_write = st_q.aw_held && st_q.w_held && !st_q.bvalid;
        if (do_write)
        begin
            st_d.aw_held = 1'b0;
            st_d.w_held  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = `DTC_AXI_OKAY;
            case (reg_sel(st_q.aw_addr))
                DTC_REG_DELAY:
                begin
                    if (!st_q.lock && st_q.w_strb[0])
                    begin
                        st_d.delay = st_q.w_data[7:0];
                    end
                end
                DTC_REG_MSB:
                begin
                    if (!st_q.lock && st_q.w_strb[0])
                    begin
                        st_d.delay_msb[`DTC_R2MSB_BIT] = st_q.w_data[`DTC_R2MSB_BIT];
                    end
                end
                DTC_REG_LOCK:
                begin
                    if (st_q.w_strb[0] && st_q.w_data[`DTC_LOCK_BIT])
                    begin
                        st_d.lock = 1'b1;
                    end
                end
                DTC_REG_STATUS:
                begin
                end
                default:
                begin
                    st_d.bresp = `DTC_AXI_SLVERR;
                end
            endcase
        end
        if (st_q.bvalid && i_bready)
        begin
            st_d.bvalid = 1'b0;
        end

        do_read = o_arready && i_arvalid;
        if (do_read)
        begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = `DTC_AXI_OKAY;
            st_d.rdata  = 32'h0000_0000;
            case (reg_sel(i_araddr))
                DTC_REG_DELAY:
                begin
                    st_d.rdata[7:0] = st_q.delay;
                end
                DTC_REG_MSB:
                begin
                    st_d.rdata[7:0] = st_q.delay_msb;
                end
                DTC_REG_LOCK:
                begin
                    st_d.rdata[`DTC_LOCK_BIT] = st_q.lock;
                end
                DTC_REG_STATUS:
                begin
                    for (int c = 0; c < 3; c++)
                    begin
                        st_d.rdata[c] = o_adjust_allowed[c];
                    end
                end
                default:
                begin
                    st_d.rresp = `DTC_AXI_SLVERR;
                end
            endcase
        end
        else if (st_q.rvalid && i_rready)
        begin
            st_d.rvalid = 1'b0;
        end

        // --------------------------------------------------------------------
        // Interval timers, saturating
        // --------------------------------------------------------------------
        for (int c = 0; c < 3; c++)
        begin
            if (i_adjust_done[c])
            begin
                st_d.cnt[c] = '0;
            end
            else if (i_mon_tick && (st_q.cnt[c] != {`DTC_CNT_W{1'b1}}))
            begin
                st_d.cnt[c] = st_q.cnt[c] + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_q           <= '0;
            st_q.delay     <= `DTC_DELAY_RST;
            st_q.delay_msb <= `DTC_MSB_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule // dtc_delay_cfg

//--- tb/dtc_delay_cfg_assertions.sv
// Port checks for the delay configuration block.
// Assumes binding to dtc_delay_cfg; sees only its ports.
`timescale 1ns/1ps
module dtc_delay_cfg_assertions (
    input wire logic              i_sys_clk,
    input wire logic              i_reset_n,
    input wire dtc_pkg::dtc_dir_t i_pending_dir [3],
    input wire logic              i_adjust_done [3],
    input wire logic              o_adjust_allowed [3],
    input wire logic [2:0]        o_local_delay_code,
    input wire logic              o_locked,
    input wire logic              i_awvalid,
    input wire logic              o_awready,
    input wire logic              i_wvalid,
    input wire logic              o_wready,
    input wire logic              o_bvalid,
    input wire logic              i_bready,
    input wire logic              i_arvalid,
    input wire logic              o_arready,
    input wire logic              o_rvalid,
    input wire logic              i_rready,
    input wire logic [31:0]       o_rdata
);
import dtc_pkg::*;
default clocking @(posedge i_sys_clk); endclocking
default disable iff (!i_reset_n);
property p_wr_resp; i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid; endproperty
a_wr_resp: assert property (p_wr_resp) else $error("write response late");
property p_rd_resp; i_arvalid && o_arready |=> o_rvalid; endproperty
a_rd_resp: assert property (p_rd_resp) else $error("read response late");
property p_b_hold; o_bvalid && !i_bready |=> o_bvalid; endproperty
a_b_hold: assert property (p_b_hold) else $error("write response dropped");
property p_r_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
a_r_hold: assert property (p_r_hold) else $error("read data dropped");
property p_upper; o_rvalid |-> o_rdata[31:8] == 24'h0; endproperty
a_upper: assert property (p_upper) else $error("upper read bits set");
property p_none; i_pending_dir[0] == DTC_DIR_NONE |-> !o_adjust_allowed[0]; endproperty
a_none: assert property (p_none) else $error("allowed with no direction");
property p_min_wait; i_adjust_done[0] |=> !o_adjust_allowed[0] [*8]; endproperty
a_min_wait: assert property (p_min_wait) else $error("allowed too soon");
property p_lock; o_locked |=> o_locked && $stable(o_local_delay_code); endproperty
a_lock: assert property (p_lock) else $error("locked code changed");
endmodule // dtc_delay_cfg_assertions

bind dtc_delay_cfg dtc_delay_cfg_assertions u_chk (.*);

//--- tb/dtc_delay_cfg_bench.sv
// Self-checking bench for the delay configuration block.
// Assumes package, design and checker are compiled first.
`timescale 1ns/1ps
module dtc_delay_cfg_bench;
import dtc_pkg::*;
logic i_sys_clk = 1'h0, i_reset_n = 1'h0, i_mon_tick = 1'h0, i_bready = 1'h0;
logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
logic [9:0] i_awaddr = 10'h0, i_araddr = 10'h0;
logic [31:0] i_wdata = 32'h0, o_rdata, x, y;
logic [3:0] i_wstrb = 4'hf;
dtc_dir_t i_pending_dir [3] = '{default: DTC_DIR_NONE};
logic i_adjust_done [3] = '{default: 1'h0};
logic o_adjust_allowed [3];
logic [2:0] o_local_delay_code, o_remote1_delay_code, o_remote2_delay_code;
logic o_locked, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
logic [1:0] o_bresp, o_rresp;
wire logic [8:0] codes = {o_remote2_delay_code, o_remote1_delay_code, o_local_delay_code};
int failures = 0, n_tests = 0, seed = 32'h8aa67025;
dtc_delay_cfg dut (.*);
always #12.5 i_sys_clk = ~i_sys_clk;
task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
        failures++;
        $display("unexpected %s: expected %h seen %h", n, e, s);
    end
endtask
task automatic close_out;
    if (failures == 0 && n_tests > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
function automatic logic exp_ok(int c, int k, dtc_dir_t d);
    return d != DTC_DIR_NONE && k >= ((d == DTC_DIR_INC ? 16 : 8) << c);
endfunction
task automatic wr(logic [9:0] a, logic [31:0] d, logic [1:0] e);
    logic ha, hw, hb;
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do
    begin
        @(negedge i_sys_clk);
        ha = i_awvalid && o_awready;
        hw = i_wvalid && o_wready;
        hb = o_bvalid;
        if (hb)
            chk("bresp", o_bresp, e);
        @(posedge i_sys_clk);
        if (ha)
            i_awvalid <= 1'h0;
        if (hw)
            i_wvalid <= 1'h0;
    end
    while (!hb);
    i_bready <= 1'h0;
endtask
task automatic rc(logic [9:0] a, logic [31:0] e, logic [1:0] er);
    logic ha, hr;
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do
    begin
        @(negedge i_sys_clk);
        ha = i_arvalid && o_arready;
        hr = o_rvalid;
        if (hr)
            chk("rdata", o_rdata, e);
        if (hr)
            chk("rresp", o_rresp, er);
        @(posedge i_sys_clk);
        if (ha)
            i_arvalid <= 1'h0;
    end
    while (!hr);
    i_rready <= 1'h0;
endtask
initial
begin
    repeat (8) @(posedge i_sys_clk);
    chk("reset codes", codes, 32'h0);
    i_reset_n <= 1'h1;
    for (int c = 0; c < 8; c++)
    begin
        x = $random(seed);
        y = $random(seed);
        wr(10'h0dc, x, 2'h0);
        wr(10'h0d8, y, 2'h0);
        rc(10'h0dc, {24'h0, x[7:0]}, 2'h0);
        rc(10'h0d8, {31'h0, y[0]}, 2'h0);
        chk("codes", codes, {y[0], x[7:6], x[2:0], x[5:3]});
        wr(10'h0dc, {x[31:8], c[1:0], c[2:0], c[2:0]}, 2'h0);
        wr(10'h0d8, {y[31:1], c[2]}, 2'h0);
        i_pending_dir <= '{DTC_DIR_DEC, DTC_DIR_INC, c[0] ? DTC_DIR_INC : DTC_DIR_DEC};
        i_adjust_done <= '{default: 1'h1};
        @(posedge i_sys_clk);
        i_adjust_done <= '{default: 1'h0};
        i_mon_tick <= 1'h1;
        for (int k = 0; k <= 16 << c; k++)
        begin
            @(negedge i_sys_clk);
            for (int j = 0; j < 3; j++)
                chk("allowed", o_adjust_allowed[j], exp_ok(c, k, i_pending_dir[j]));
            @(posedge i_sys_clk);
        end
        i_mon_tick <= 1'h0;
        rc(10'h110, 32'h7, 2'h0);
    end
    rc(10'h010, 32'h0, 2'h2);
    rc(10'h0dd, 32'h0, 2'h2);
    wr(10'h010, x, 2'h2);
    wr(10'h100, 32'h2, 2'h0);
    chk("locked", o_locked, 32'h1);
    rc(10'h100, 32'h2, 2'h0);
    wr(10'h0dc, 32'h0, 2'h0);
    rc(10'h0dc, 32'hff, 2'h0);
    wr(10'h0d8, 32'h0, 2'h0);
    rc(10'h0d8, 32'h1, 2'h0);
    close_out();
end
initial
begin
    #1000000;
    failures++;
    close_out();
end
endmodule // dtc_delay_cfg_bench
